// *** smr_regs.vh ***
// Register map, field positions, reset values and timing counts of the mode register bank.
// Assumes inclusion by bare name from the design files.
`ifndef SMR_REGS_VH
`define SMR_REGS_VH

// ----------------------------------------------------------------
// Control word layout
// ----------------------------------------------------------------
`define SMR_WORD_BITS 16
`define SMR_WORD_DIR_BIT 15
`define SMR_WORD_IDX_HI 14
`define SMR_WORD_IDX_LO 8
`define SMR_WORD_DATA_HI 7
`define SMR_HALF_WORD_BITS 8

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define SMR_IDX_RSVD_LOW 7'h00
`define SMR_IDX_ATTEN_FIRST 7'h01
`define SMR_IDX_ATTEN_LAST 7'h06
`define SMR_IDX_ATTEN_MUTE 7'h07
`define SMR_IDX_CH_ENABLE 7'h08
`define SMR_IDX_FORMAT 7'h09
`define SMR_IDX_DEEMPH 7'h0A
`define SMR_IDX_READBACK 7'h0B
`define SMR_IDX_RSVD_HIGH 7'h0C
`define SMR_NUM_REGS 12

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SMR_AM_LOAD_BIT 7
`define SMR_AM_RATE_BIT 6
`define SMR_CE_ZERO_BIT 6
`define SMR_FF_FILTER_BIT 5
`define SMR_FF_DIVIDE_BIT 4
`define SMR_FF_CLKEN_BIT 3
`define SMR_DE_RATE_HI 4
`define SMR_DE_RATE_LO 3
`define SMR_RB_INC_BIT 7

// ----------------------------------------------------------------
// Reset values and writable bit masks
// ----------------------------------------------------------------
`define SMR_RST_ATTEN 8'hFF
`define SMR_RST_ATTEN_MUTE 8'h00
`define SMR_RST_CH_ENABLE 8'h00
`define SMR_RST_FORMAT 8'h00
`define SMR_RST_DEEMPH 8'h00
`define SMR_RST_READBACK 8'h01
`define SMR_MASK_FULL 8'hFF
`define SMR_MASK_CH_ENABLE 8'h7F
`define SMR_MASK_FORMAT 8'h3F
`define SMR_MASK_DEEMPH 8'h1F

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define SMR_SYNC_STAGES 2
`define SMR_CNT_W 11
`define SMR_CNT_MAX 11'h7FF
`define SMR_HALF_WORD_CNT 11'h008
`define SMR_WORD_CNT 11'h010

`endif

// *** smr_sync.v ***
// Two-flip-flop synchroniser for a group of level inputs.
// Assumes the inputs are quasi-static with respect to the sampling clock.
`timescale 1ns/100ps
module smr_sync #(
  parameter W = 3,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);

  // ----------------------------------------------------------------
  // Synchroniser stages
  // ----------------------------------------------------------------
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= RST;
      sync_r <= RST;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;

endmodule

// *** smr_top.v ***
// Mode register bank with its four-wire serial control port, write and readback paths.
// Assumes the control pins come from an unrelated clock domain and the bit clock is slow.
`timescale 1ns/100ps
`include "smr_regs.vh"
module smr_top (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_control_latch_line,
  input wire i_control_bit_clock,
  input wire i_control_serial_in,
  output wire o_control_serial_out,
  output wire o_control_serial_out_oe_n,
  output wire [47:0] o_attenuation_levels,
  output wire o_attenuation_load_enable,
  output wire o_attenuation_rate_select,
  output wire [5:0] o_soft_silence,
  output wire o_zero_input_silence_enable,
  output wire [5:0] o_converter_control,
  output wire [2:0] o_audio_word_format,
  output wire o_filter_rolloff_select,
  output wire o_clock_output_divide,
  output wire o_clock_output_enable,
  output wire [1:0] o_deemph_rate_select,
  output wire [2:0] o_deemph_enable,
  output wire [6:0] o_readback_index,
  output wire o_readback_auto_increment
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  wire [2:0] pins_sync;

  // Reset history matches the idle pins, so no false edge follows reset.
  smr_sync #(
    .W(3),
    .RST(3'h6)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_control_latch_line, i_control_bit_clock, i_control_serial_in}),
    .o_sync(pins_sync)
  );

  wire latch_s = pins_sync[2];
  wire bclk_s = pins_sync[1];
  wire sdin_s = pins_sync[0];

  reg latch_d_r;
  reg bclk_d_r;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      latch_d_r <= 1'b1;
      bclk_d_r <= 1'b1;
    end else begin
      latch_d_r <= latch_s;
      bclk_d_r <= bclk_s;
    end
  end

  wire latch_fall = latch_d_r & ~latch_s;
  wire latch_rise = ~latch_d_r & latch_s;
  wire bclk_rise = ~bclk_d_r & bclk_s;
  wire bclk_fall = bclk_d_r & ~bclk_s;

  // ----------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------
  reg active_r;
  reg active_nxt;
  reg [`SMR_CNT_W-1:0] cnt_r;
  reg [`SMR_CNT_W-1:0] cnt_nxt;
  reg [`SMR_WORD_BITS-1:0] shift_r;
  reg [`SMR_WORD_BITS-1:0] shift_nxt;
  reg read_r;
  reg read_nxt;
  reg auto_r;
  reg auto_nxt;
  reg [6:0] last_r;
  reg [6:0] last_nxt;

  wire [7:0] readback_reg;
  wire rb_auto = readback_reg[`SMR_RB_INC_BIT];
  wire [6:0] rb_index = readback_reg[6:0];

  always @* begin
    active_nxt = active_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    read_nxt = read_r;
    auto_nxt = auto_r;
    last_nxt = last_r;
    if (latch_fall) begin
      active_nxt = 1'b1;
      cnt_nxt = {`SMR_CNT_W{1'b0}};
      shift_nxt = {`SMR_WORD_BITS{1'b0}};
      read_nxt = 1'b0;
      auto_nxt = rb_auto;
      last_nxt = rb_index;
    end else if (latch_rise) begin
      active_nxt = 1'b0;
      read_nxt = 1'b0;
    end else if (active_r && bclk_rise) begin
      if (cnt_r < `SMR_WORD_CNT) begin
        shift_nxt = {shift_r[`SMR_WORD_BITS-2:0], sdin_s};
      end
      if (cnt_r == {`SMR_CNT_W{1'b0}}) begin
        read_nxt = sdin_s;
      end
      if (cnt_r != `SMR_CNT_MAX) begin
        cnt_nxt = cnt_r + {{(`SMR_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      active_r <= 1'b0;
      cnt_r <= {`SMR_CNT_W{1'b0}};
      shift_r <= {`SMR_WORD_BITS{1'b0}};
      read_r <= 1'b0;
      auto_r <= 1'b0;
      last_r <= 7'h00;
    end else begin
      active_r <= active_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      read_r <= read_nxt;
      auto_r <= auto_nxt;
      last_r <= last_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Write strobe
  // ----------------------------------------------------------------
  wire word_full = (cnt_r == `SMR_WORD_CNT);
  wire wr_now = active_r & latch_rise & word_full & ~shift_r[`SMR_WORD_DIR_BIT];
  wire [6:0] wr_index = shift_r[`SMR_WORD_IDX_HI:`SMR_WORD_IDX_LO];
  wire [7:0] wr_data = shift_r[`SMR_WORD_DATA_HI:0];

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  wire [8*`SMR_NUM_REGS-1:0] bank_w;

  assign bank_w[7:0] = 8'h00;

  genvar gi;
  generate
    for (gi = 1; gi < `SMR_NUM_REGS; gi = gi + 1) begin : g_reg
      localparam [7:0] RST_VAL =
        (gi <= 6) ? `SMR_RST_ATTEN :
        (gi == 7) ? `SMR_RST_ATTEN_MUTE :
        (gi == 8) ? `SMR_RST_CH_ENABLE :
        (gi == 9) ? `SMR_RST_FORMAT :
        (gi == 10) ? `SMR_RST_DEEMPH :
        `SMR_RST_READBACK;
      localparam [7:0] MASK =
        (gi == 8) ? `SMR_MASK_CH_ENABLE :
        (gi == 9) ? `SMR_MASK_FORMAT :
        (gi == 10) ? `SMR_MASK_DEEMPH : `SMR_MASK_FULL;
      localparam [31:0] IDX_W = gi;
      localparam [6:0] IDX = IDX_W[6:0];
      reg [7:0] val_r;
      always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          val_r <= RST_VAL;
        end else if (wr_now && (wr_index == IDX)) begin
          val_r <= wr_data & MASK;
        end
      end
      assign bank_w[8*gi+7:8*gi] = val_r;
    end
  endgenerate

  assign readback_reg = bank_w[8*11+7:8*11];

  // ----------------------------------------------------------------
  // Readback path
  // ----------------------------------------------------------------
  function [7:0] read_byte;
    input [7:0] idx;
    input [8*`SMR_NUM_REGS-1:0] bank;
    begin
      if (idx >= 8'h01 && idx < 8'h0C) begin
        read_byte = bank[8*idx +: 8];
      end else begin
        read_byte = 8'h00;
      end
    end
  endfunction

  wire [`SMR_CNT_W-1:0] pos = cnt_r - `SMR_HALF_WORD_CNT;
  wire [7:0] word_num = pos[`SMR_CNT_W-1:3];
  wire [7:0] auto_idx = word_num + 8'h01;
  wire [7:0] single_idx = {1'b0, last_r};
  wire [7:0] sel_idx = auto_r ? auto_idx : single_idx;
  wire [7:0] sel_byte = read_byte(sel_idx, bank_w);
  wire past_half = (cnt_r >= `SMR_HALF_WORD_CNT);
  wire in_range = auto_r ? (auto_idx <= {1'b0, last_r}) : (word_num == 8'h00);

  reg sdout_r;
  reg sdout_nxt;
  reg oe_n_r;
  reg oe_n_nxt;

  always @* begin
    sdout_nxt = sdout_r;
    oe_n_nxt = oe_n_r;
    if (!active_r || latch_rise || latch_fall) begin
      sdout_nxt = 1'b0;
      oe_n_nxt = 1'b1;
    end else if (bclk_fall && read_r) begin
      if (past_half && in_range) begin
        sdout_nxt = sel_byte[~pos[2:0]];
        oe_n_nxt = 1'b0;
      end else begin
        sdout_nxt = 1'b0;
        oe_n_nxt = 1'b1;
      end
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sdout_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else begin
      sdout_r <= sdout_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_control_serial_out = sdout_r;
  assign o_control_serial_out_oe_n = oe_n_r;
  assign o_attenuation_levels = bank_w[8*7-1:8];
  assign o_attenuation_load_enable = bank_w[8*7+`SMR_AM_LOAD_BIT];
  assign o_attenuation_rate_select = bank_w[8*7+`SMR_AM_RATE_BIT];
  assign o_soft_silence = bank_w[8*7+5:8*7];
  assign o_zero_input_silence_enable = bank_w[8*8+`SMR_CE_ZERO_BIT];
  assign o_converter_control = bank_w[8*8+5:8*8];
  assign o_audio_word_format = bank_w[8*9+2:8*9];
  assign o_filter_rolloff_select = bank_w[8*9+`SMR_FF_FILTER_BIT];
  assign o_clock_output_divide = bank_w[8*9+`SMR_FF_DIVIDE_BIT];
  assign o_clock_output_enable = bank_w[8*9+`SMR_FF_CLKEN_BIT];
  assign o_deemph_rate_select = bank_w[8*10+`SMR_DE_RATE_HI:8*10+`SMR_DE_RATE_LO];
  assign o_deemph_enable = bank_w[8*10+2:8*10];
  assign o_readback_index = rb_index;
  assign o_readback_auto_increment = rb_auto;

endmodule

// *** smr_checker.sv ***
// Assertions on the serial control port and configuration outputs of smr_top.
// Assumes binding to smr_top and a host that keeps the latch high between frames.
`timescale 1ns/100ps
module smr_checker (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_control_latch_line,
  input wire i_control_bit_clock,
  input wire o_control_serial_out,
  input wire o_control_serial_out_oe_n,
  input wire [47:0] o_attenuation_levels,
  input wire [6:0] o_readback_index,
  input wire o_readback_auto_increment
);
  // ----------------------------------------------------------------
  // Rise counter and assertions
  // ----------------------------------------------------------------
  logic bc_q;
  logic [5:0] rises;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bc_q <= 1'b1;
      rises <= 6'h00;
    end else begin
      bc_q <= i_control_bit_clock;
      if (i_control_latch_line) rises <= 6'h00;
      else if (i_control_bit_clock && !bc_q) rises <= rises + 6'h01;
    end
  end
  chk_reset_values: assert property (
    $rose(i_rst_n) |-> o_control_serial_out_oe_n && !o_readback_auto_increment &&
      o_attenuation_levels == {6{8'hFF}} && o_readback_index == 7'h01)
    else $error("Reset values wrong.");
  chk_released_low: assert property (
    o_control_serial_out_oe_n |-> !o_control_serial_out)
    else $error("Released output not low.");
  chk_drive_late: assert property (
    !o_control_serial_out_oe_n && !i_control_latch_line |-> rises >= 6'h08)
    else $error("Output driven before eight rises.");
  chk_drive_on_fall: assert property (
    $fell(o_control_serial_out_oe_n) |-> !$past(i_control_bit_clock, 3))
    else $error("Drive start not after a fall.");
  chk_shift_on_fall: assert property (
    !o_control_serial_out_oe_n && $changed(o_control_serial_out)
      |-> !$past(i_control_bit_clock, 3))
    else $error("Data changed away from a fall.");
  chk_latch_release: assert property (
    $rose(i_control_latch_line) |-> ##[1:8] o_control_serial_out_oe_n)
    else $error("Output not released after latch rise.");
  chk_cfg_on_latch: assert property (
    $changed(o_attenuation_levels) || $changed(o_readback_index)
      |-> $past(i_control_latch_line, 2) && i_control_latch_line)
    else $error("Register changed without latch rise.");
  chk_cfg_hold: assert property (
    !i_control_latch_line |=> $stable(o_readback_auto_increment))
    else $error("Auto flag changed inside a frame.");
  cov_drive: cover property ($fell(o_control_serial_out_oe_n));
  cov_auto: cover property (o_readback_auto_increment && rises == 6'h20);
  cov_write: cover property ($changed(o_attenuation_levels));
endmodule
bind smr_top smr_checker smr_checker_i (.*);

// *** smr_host_model.sv ***
// Host controller model driving the four-wire serial control port.
// Assumes it is called just after an i_clk edge; bit clock half period is H clocks.
`timescale 1ns/100ps
module smr_host_model #(
  parameter int H = 4
) (
  input wire i_clk,
  input wire i_dout,
  input wire i_dout_oe_n,
  output logic o_latch,
  output logic o_bclk,
  output logic o_din
);
  // ----------------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------------
  logic [63:0] rx;
  initial begin
    o_latch = 1'b1;
    o_bclk = 1'b1;
    o_din = 1'b0;
    rx = 64'h0;
  end
  task automatic frame(input logic [15:0] w, input int n);
    int k;
    o_latch <= 1'b0;
    repeat (H) @(posedge i_clk);
    for (k = 0; k < n; k++) begin
      o_bclk <= 1'b0;
      o_din <= (k < 16) ? w[15 - k] : ~o_din;
      repeat (H) @(posedge i_clk);
      o_bclk <= 1'b1;
      repeat (H) @(posedge i_clk);
      rx = {rx[62:0], i_dout_oe_n ? 1'bz : i_dout};
    end
    o_latch <= 1'b1;
    o_din <= ~o_din;
    repeat (8) @(posedge i_clk);
  endtask
endmodule

// *** smr_top_tb.sv ***
// Self-checking bench for the mode register bank and its serial control port.
// Assumes smr_host_model on the far side and the checker bound to smr_top.
`timescale 1ns/100ps
module smr_top_tb;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  wire ml, mc, control_serial_in, dout, oe_n, ld, rate, zd, flt, div, cke, inc;
  wire [47:0] atten;
  wire [5:0] mute, conv;
  wire [2:0] fmt, dem;
  wire [1:0] drate;
  wire [6:0] ridx;
  int fails = 0;
  int checks = 0;
  always #10 i_clk = ~i_clk;
  smr_host_model smr_host_model_i (.i_clk(i_clk), .i_dout(dout), .i_dout_oe_n(oe_n),
    .o_latch(ml), .o_bclk(mc), .o_din(control_serial_in));
  smr_top smr_top_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_control_latch_line(ml),
    .i_control_bit_clock(mc), .i_control_serial_in(control_serial_in), .o_control_serial_out(dout),
    .o_control_serial_out_oe_n(oe_n), .o_attenuation_levels(atten),
    .o_attenuation_load_enable(ld), .o_attenuation_rate_select(rate), .o_soft_silence(mute),
    .o_zero_input_silence_enable(zd), .o_converter_control(conv), .o_audio_word_format(fmt),
    .o_filter_rolloff_select(flt), .o_clock_output_divide(div), .o_clock_output_enable(cke),
    .o_deemph_rate_select(drate), .o_deemph_enable(dem), .o_readback_index(ridx),
    .o_readback_auto_increment(inc));
  // ----------------------------------------------------------------
  // Shared tasks and scenarios
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    smr_host_model_i.frame({1'b0, idx, d}, 16);
  endtask
  task automatic rd(input logic [6:0] idx, input logic [7:0] exp);
    wr(7'h0B, {1'b0, idx});
    smr_host_model_i.frame(16'h8000, 16);
    chk("single read", smr_host_model_i.rx[15:0], {8'hZZ, exp});
  endtask
  task automatic t_reset();
    chk("attenuation", atten, {6{8'hFF}});
    chk("reg7", {ld, rate, mute}, 8'h00);
    chk("reg8", {zd, conv}, 7'h00);
    chk("reg9", {flt, div, cke, fmt}, 6'h00);
    chk("reg10", {drate, dem}, 5'h00);
    chk("reg11", {inc, ridx}, 8'h01);
    chk("released output", {oe_n, dout}, 2'h2);
    rd(7'h09, 8'h00);
  endtask
  task automatic t_write_read();
    logic [7:0] m;
    for (int i = 1; i <= 10; i++) wr(i[6:0], 8'hE0 | i[7:0]);
    chk("attenuation", atten, 48'hE6E5E4E3E2E1);
    chk("reg7", {ld, rate, mute}, 8'hE7);
    chk("reg8", {zd, conv}, 7'h68);
    chk("reg9", {flt, div, cke, fmt}, 6'h29);
    chk("reg10", {drate, dem}, 5'h0A);
    for (int i = 1; i <= 10; i++) begin
      m = (i == 8) ? 8'h7F : (i == 9) ? 8'h3F : (i == 10) ? 8'h1F : 8'hFF;
      rd(i[6:0], m & (8'hE0 | i[7:0]));
    end
  endtask
  task automatic t_index_ignored();
    wr(7'h0B, 8'h02);
    smr_host_model_i.frame(16'h8500, 16);
    chk("index ignored", smr_host_model_i.rx[15:0], 16'hZZE2);
  endtask
  task automatic t_auto();
    wr(7'h0B, 8'h83);
    smr_host_model_i.frame(16'h8000, 32);
    chk("auto read", smr_host_model_i.rx[31:0], 32'hZZE1E2E3);
    chk("no write", atten, 48'hE6E5E4E3E2E1);
  endtask
  task automatic t_abort();
    smr_host_model_i.frame(16'h0111, 10);
    smr_host_model_i.frame(16'h0111, 17);
    chk("aborted", atten[7:0], 8'hE1);
  endtask
  task automatic t_mid_reset();
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    t_reset();
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    fails++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    t_reset();
    t_write_read();
    t_index_ignored();
    t_auto();
    t_abort();
    t_mid_reset();
    print_verdict();
  end
endmodule
